// >>> verilog/rtcv_regs.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Minutes tens: 3-bit BCD in bits 14..12, values 0..5.
// - Minutes ones: 4-bit BCD in bits 11..8, values 0..9.
// - Seconds tens: 3-bit BCD in bits 6..4, values 0..5.
// - Seconds ones: 4-bit BCD in bits 3..0, values 0..9.
// - Unimplemented bits read zero, writes to them ignored.
// - Minutes/seconds fields writable by software and by clock hardware.
// - Alarm day tens: 2-bit BCD in bits 5..4, values 0..3.
// - Alarm weekday: 3 bits in bits 10..8, values 0..6.
// - Alarm hour tens: 2-bit BCD in bits 5..4, values 0..2.
// - Alarm hour ones: 4-bit BCD in bits 3..0, values 0..9.
// - Alarm registers take writes only while write enable is one.
// - Alarm digits compared with clock digits, mask selects digits.
module rtcv_regs
	import rtcv_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hw_update,
	input wire logic [15:0] hw_time_minutes_seconds,
	input wire logic [15:0] clk_month_day,
	input wire logic [15:0] clk_weekday_digit_hour,
	output logic [15:0] time_minutes_seconds,
	output logic alarm_match
);
	logic [15:0] alarm_month_day, alarm_weekday_hours;
	logic clock_write_enable;
	logic [3:0] alarm_match_mask;
	logic [15:0] next_time_minutes_seconds, next_almd, next_alwh;
	logic next_wren;
	logic [3:0] next_mask;
	logic [31:0] next_prdata;
	logic next_pslverr, next_match;
	logic match_c;
	logic access, setup, wr, rd;
	logic [15:0] wdata16;

	// Lane-merged 16-bit write data
	function automatic logic [15:0] rtcv_merge(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] strb);
		rtcv_merge = {strb[1] ? nw[15:8] : old[15:8],
			strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	function automatic logic rtcv_mapped(input logic [7:0] a);
		rtcv_mapped = (a == RTCV_OFS_TIME_MINUTES_SECONDS) || (a == RTCV_OFS_ALMD) ||
			(a == RTCV_OFS_ALWH) || (a == RTCV_OFS_CTRL) ||
			(a == RTCV_OFS_CLOCK_DAY) || (a == RTCV_OFS_CLOCK_WH) ||
			(a == RTCV_OFS_STATUS);
	endfunction

	rtcv_alarm_cmp u_cmp (
		.clk_time_minutes_seconds(time_minutes_seconds),
		.clk_month_day(clk_month_day),
		.clk_weekday_digit_hour(clk_weekday_digit_hour),
		.alm_time_minutes_seconds(RTCV_TIME_MINUTES_SECONDS_RESET),
		.alm_month_day(alarm_month_day),
		.alm_weekday_digit_hour(alarm_weekday_hours),
		.alarm_match_mask(alarm_match_mask),
		.match(match_c)
	);

	always_comb begin
		access = psel && penable;
		setup = psel && !penable;
		wr = access && pwrite;
		// Read data prepared in setup so it stands during the access cycle
		rd = setup && !pwrite;
		wdata16 = pwdata[15:0];
		next_time_minutes_seconds = time_minutes_seconds;
		next_almd = alarm_month_day;
		next_alwh = alarm_weekday_hours;
		next_wren = clock_write_enable;
		next_mask = alarm_match_mask;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		next_match = match_c;
		// Hardware tick loses to a software write in the same cycle
		if (hw_update) begin
			next_time_minutes_seconds = hw_time_minutes_seconds & RTCV_MASK_TIME_MINUTES_SECONDS;
		end
		if (wr) begin
			case (paddr)
				RTCV_OFS_TIME_MINUTES_SECONDS: begin
					next_time_minutes_seconds = rtcv_merge(time_minutes_seconds, wdata16,
						pstrb[1:0]) & RTCV_MASK_TIME_MINUTES_SECONDS;
				end
				RTCV_OFS_ALMD: begin
					if (clock_write_enable) begin
						next_almd = rtcv_merge(alarm_month_day, wdata16,
							pstrb[1:0]) & RTCV_MASK_ALMD;
					end
				end
				RTCV_OFS_ALWH: begin
					if (clock_write_enable) begin
						next_alwh = rtcv_merge(alarm_weekday_hours, wdata16,
							pstrb[1:0]) & RTCV_MASK_ALWH;
					end
				end
				RTCV_OFS_CTRL: begin
					if (pstrb[0]) begin
						next_wren = pwdata[RTCV_CTRL_WREN_BIT];
						next_mask = pwdata[RTCV_CTRL_MASK_LSB +: 4];
					end
				end
				default: begin
				end
			endcase
		end
		// Error flag raised from setup so it is valid at the access edge
		if (setup) begin
			next_pslverr = !rtcv_mapped(paddr);
		end
		if (rd) begin
			case (paddr)
				RTCV_OFS_TIME_MINUTES_SECONDS: next_prdata = {16'h0000, time_minutes_seconds};
				RTCV_OFS_ALMD: next_prdata = {16'h0000, alarm_month_day};
				RTCV_OFS_ALWH: next_prdata = {16'h0000, alarm_weekday_hours};
				RTCV_OFS_CTRL: next_prdata = {24'h000000, alarm_match_mask,
					3'h0, clock_write_enable};
				RTCV_OFS_CLOCK_DAY: next_prdata = {16'h0000, clk_month_day};
				RTCV_OFS_CLOCK_WH: next_prdata = {16'h0000, clk_weekday_digit_hour};
				RTCV_OFS_STATUS: next_prdata = {31'h00000000, alarm_match};
				default: next_prdata = 32'h00000000;
			endcase
		end
	end

	// Zero-wait slave: pready registered high, data ready in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_minutes_seconds <= RTCV_TIME_MINUTES_SECONDS_RESET;
			alarm_month_day <= RTCV_ALARM_RESET;
			alarm_weekday_hours <= RTCV_ALARM_RESET;
			clock_write_enable <= 1'b0;
			alarm_match_mask <= RTCV_MASK_RESET;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			pready <= 1'b0;
			alarm_match <= 1'b0;
		end else begin
			time_minutes_seconds <= next_time_minutes_seconds;
			alarm_month_day <= next_almd;
			alarm_weekday_hours <= next_alwh;
			clock_write_enable <= next_wren;
			alarm_match_mask <= next_mask;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			pready <= 1'b1;
			alarm_match <= next_match;
		end
	end

	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	time_minutes_seconds_unused_a: assert property (
		(time_minutes_seconds & ~RTCV_MASK_TIME_MINUTES_SECONDS) == 16'h0000)
		else $error("time_minutes_seconds unused bits set");
	alarm_unused_a: assert property (
		((alarm_month_day & ~RTCV_MASK_ALMD) == 16'h0000) &&
		((alarm_weekday_hours & ~RTCV_MASK_ALWH) == 16'h0000))
		else $error("alarm unused bits set");
	alarm_locked_a: assert property (
		wr && !clock_write_enable |=> $stable(alarm_month_day) &&
		$stable(alarm_weekday_hours))
		else $error("alarm written while locked");
	almd_write_a: assert property (
		wr && clock_write_enable && paddr == RTCV_OFS_ALMD &&
		pstrb[1:0] == 2'b11 |=> alarm_month_day ==
		($past(pwdata[15:0]) & RTCV_MASK_ALMD))
		else $error("alarm month day write lost");
	alwh_write_a: assert property (
		wr && clock_write_enable && paddr == RTCV_OFS_ALWH &&
		pstrb[1:0] == 2'b11 |=> alarm_weekday_hours[10:0] ==
		($past(pwdata[10:0]) & RTCV_MASK_ALWH[10:0]))
		else $error("alarm weekday hours write lost");
	alarm_sw_only_a: assert property (
		!wr |=> $stable(alarm_month_day) && $stable(alarm_weekday_hours))
		else $error("alarm changed without write");
	hw_update_a: assert property (
		hw_update && !wr |=> time_minutes_seconds ==
		($past(hw_time_minutes_seconds) & RTCV_MASK_TIME_MINUTES_SECONDS))
		else $error("hardware update lost");
	time_minutes_seconds_write_a: assert property (
		wr && paddr == RTCV_OFS_TIME_MINUTES_SECONDS && pstrb[1:0] == 2'b11 |=>
		time_minutes_seconds[14:12] == $past(pwdata[14:12]) &&
		time_minutes_seconds[11:8] == $past(pwdata[11:8]) &&
		time_minutes_seconds[6:4] == $past(pwdata[6:4]) &&
		time_minutes_seconds[3:0] == $past(pwdata[3:0]))
		else $error("time_minutes_seconds write lost");
	match_mask_a: assert property (
		alarm_match_mask == RTCV_AM_SEC |=> alarm_match)
		else $error("every-second match missing");

	// Bus answer timing
	pready_access_a: assert property (
		psel && penable |-> pready)
		else $error("pready low in access phase");

	slverr_unmapped_a: assert property (
		psel && !penable && !rtcv_mapped(paddr) |=> pslverr)
		else $error("missing error on unmapped address");

	slverr_mapped_a: assert property (
		psel && !penable && rtcv_mapped(paddr) |=> !pslverr)
		else $error("error on mapped address");

	slverr_idle_a: assert property (
		!(psel && !penable) |=> !pslverr)
		else $error("error outside access phase");

	// Read data mirrors the register seen in the setup cycle
	read_time_minutes_seconds_a: assert property (
		psel && !penable && !pwrite && paddr == RTCV_OFS_TIME_MINUTES_SECONDS |=>
		prdata == {16'h0000, $past(time_minutes_seconds)})
		else $error("time_minutes_seconds read data wrong");

	read_almd_a: assert property (
		psel && !penable && !pwrite && paddr == RTCV_OFS_ALMD |=>
		prdata == {16'h0000, $past(alarm_month_day)})
		else $error("alarm month day read data wrong");

	read_alwh_a: assert property (
		psel && !penable && !pwrite && paddr == RTCV_OFS_ALWH |=>
		prdata == {16'h0000, $past(alarm_weekday_hours)})
		else $error("alarm weekday hours read data wrong");

	upper_zero_a: assert property (
		prdata[31:16] == 16'h0000)
		else $error("upper read half not zero");

	prdata_hold_a: assert property (
		!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed without read");

	// Control bits land only through a low-lane write
	ctrl_write_a: assert property (
		wr && paddr == RTCV_OFS_CTRL && pstrb[0] |=>
		clock_write_enable == $past(pwdata[RTCV_CTRL_WREN_BIT]) &&
		alarm_match_mask == $past(pwdata[7:4]))
		else $error("control write lost");

	// Software write has priority over a hardware tick
	sw_wins_a: assert property (
		hw_update && wr && paddr == RTCV_OFS_TIME_MINUTES_SECONDS &&
		pstrb[1:0] == 2'b11 |=> time_minutes_seconds ==
		($past(pwdata[15:0]) & RTCV_MASK_TIME_MINUTES_SECONDS))
		else $error("hardware tick beat software write");

	unmapped_write_a: assert property (
		wr && !rtcv_mapped(paddr) |=> $stable(clock_write_enable) &&
		$stable(alarm_match_mask) && $stable(alarm_month_day))
		else $error("unmapped write changed state");

	match_follow_a: assert property (
		1'b1 |=> alarm_match == $past(match_c))
		else $error("alarm match not registered");

	reserved_mask_a: assert property (
		alarm_match_mask > 4'h9 |=> !alarm_match)
		else $error("reserved mask matched");

	locked_write_c: cover property (wr && !clock_write_enable &&
		paddr == RTCV_OFS_ALMD);
	open_write_c: cover property (wr && clock_write_enable &&
		paddr == RTCV_OFS_ALWH);
	hw_tick_c: cover property (hw_update ##1 rd && paddr == RTCV_OFS_TIME_MINUTES_SECONDS);
	match_c_c: cover property ($rose(alarm_match));
endmodule
`default_nettype wire

// >>> shared/rtcv_pkg.sv
package rtcv_pkg;
	// Byte offsets on the APB
	localparam logic [7:0] RTCV_OFS_TIME_MINUTES_SECONDS = 8'h00;
	localparam logic [7:0] RTCV_OFS_ALMD = 8'h04;
	localparam logic [7:0] RTCV_OFS_ALWH = 8'h08;
	localparam logic [7:0] RTCV_OFS_CTRL = 8'h0C;
	localparam logic [7:0] RTCV_OFS_CLOCK_DAY = 8'h10;
	localparam logic [7:0] RTCV_OFS_CLOCK_WH = 8'h14;
	localparam logic [7:0] RTCV_OFS_STATUS = 8'h18;
	// Implemented bit masks
	localparam logic [15:0] RTCV_MASK_TIME_MINUTES_SECONDS = 16'h7F7F;
	localparam logic [15:0] RTCV_MASK_ALMD = 16'h1F3F;
	localparam logic [15:0] RTCV_MASK_ALWH = 16'h073F;
	// Field positions
	localparam int RTCV_MIN_TENS_LSB = 12;
	localparam int RTCV_MIN_ONES_LSB = 8;
	localparam int RTCV_SEC_TENS_LSB = 4;
	localparam int RTCV_SEC_ONES_LSB = 0;
	localparam int RTCV_MONTH_TENS_LSB = 12;
	localparam int RTCV_MONTH_ONES_LSB = 8;
	localparam int RTCV_DAY_TENS_LSB = 4;
	localparam int RTCV_DAY_ONES_LSB = 0;
	localparam int RTCV_WEEKDAY_DIGIT_LSB = 8;
	localparam int RTCV_HOUR_TENS_LSB = 4;
	localparam int RTCV_HOUR_ONES_LSB = 0;
	// Control register fields
	localparam int RTCV_CTRL_WREN_BIT = 0;
	localparam int RTCV_CTRL_MASK_LSB = 4;
	// Reset values
	localparam logic [15:0] RTCV_TIME_MINUTES_SECONDS_RESET = 16'h0000;
	localparam logic [15:0] RTCV_ALARM_RESET = 16'h0000;
	localparam logic [3:0] RTCV_MASK_RESET = 4'h0;
	// Alarm mask encodings
	typedef enum logic [3:0] {
		RTCV_AM_HALF_SEC = 4'h0,
		RTCV_AM_SEC = 4'h1,
		RTCV_AM_10SEC = 4'h2,
		RTCV_AM_MIN = 4'h3,
		RTCV_AM_10MIN = 4'h4,
		RTCV_AM_HOUR = 4'h5,
		RTCV_AM_DAY = 4'h6,
		RTCV_AM_WEEK = 4'h7,
		RTCV_AM_MONTH = 4'h8,
		RTCV_AM_YEAR = 4'h9
	} rtcv_alarm_match_mask_t;
endpackage

// >>> verilog/rtcv_alarm_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// Digit compare; how many digits count is set by the mask
module rtcv_alarm_cmp
	import rtcv_pkg::*;
(
	input wire logic [15:0] clk_time_minutes_seconds,
	input wire logic [15:0] clk_month_day,
	input wire logic [15:0] clk_weekday_digit_hour,
	input wire logic [15:0] alm_time_minutes_seconds,
	input wire logic [15:0] alm_month_day,
	input wire logic [15:0] alm_weekday_digit_hour,
	input wire logic [3:0] alarm_match_mask,
	output logic match
);
	logic s1, s10, m1, m10, h, d, wd, mo;

	always_comb begin
		s1 = clk_time_minutes_seconds[3:0] == alm_time_minutes_seconds[3:0];
		s10 = clk_time_minutes_seconds[6:4] == alm_time_minutes_seconds[6:4];
		m1 = clk_time_minutes_seconds[11:8] == alm_time_minutes_seconds[11:8];
		m10 = clk_time_minutes_seconds[14:12] == alm_time_minutes_seconds[14:12];
		h = clk_weekday_digit_hour[5:0] == alm_weekday_digit_hour[5:0];
		wd = clk_weekday_digit_hour[10:8] == alm_weekday_digit_hour[10:8];
		d = clk_month_day[5:0] == alm_month_day[5:0];
		mo = clk_month_day[12:8] == alm_month_day[12:8];
		case (alarm_match_mask)
			RTCV_AM_HALF_SEC: match = 1'b1;
			RTCV_AM_SEC: match = 1'b1;
			RTCV_AM_10SEC: match = s1;
			RTCV_AM_MIN: match = s1 && s10;
			RTCV_AM_10MIN: match = s1 && s10 && m1;
			RTCV_AM_HOUR: match = s1 && s10 && m1 && m10;
			RTCV_AM_DAY: match = s1 && s10 && m1 && m10 && h;
			RTCV_AM_WEEK: match = s1 && s10 && m1 && m10 && h && wd;
			RTCV_AM_MONTH: match = s1 && s10 && m1 && m10 && h && d;
			RTCV_AM_YEAR: match = s1 && s10 && m1 && m10 && h && d && mo;
			default: match = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// >>> verification/rtcv_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rtcv_regs_tb
	import rtcv_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic hw_update, alarm_match;
	logic [7:0] paddr;
	logic [3:0] pstrb;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] hw_time_minutes_seconds, clk_month_day, clk_weekday_digit_hour, tms, v, w;
	int n_mismatch, check_count, seed, i;
	rtcv_regs rtcv_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hw_update(hw_update), .hw_time_minutes_seconds(hw_time_minutes_seconds),
		.clk_month_day(clk_month_day), .clk_weekday_digit_hour(clk_weekday_digit_hour),
		.time_minutes_seconds(tms), .alarm_match(alarm_match));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	function automatic logic [15:0] rn(input int n);
		return 16'($unsigned($random(seed)) % n);
	endfunction
	// Digits packed at the positions shared by all three registers
	function automatic logic [15:0] pack(input logic [15:0] a, b, c, d);
		return (a << 12) | (b << 8) | (c << 4) | d;
	endfunction
	task automatic stop_test();
		$display("Mismatches %0d, checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Read data and error taken at the edge that completes the access
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_mismatch++;
			stop_test();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic settle();
		repeat (2) @(posedge pclk);
	endtask
	initial begin
		seed = 32'hadde8d4b;
		n_mismatch = 0;
		check_count = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h3;
		hw_update = 1'b0;
		hw_time_minutes_seconds = 16'h0;
		clk_month_day = 16'h0;
		clk_weekday_digit_hour = 16'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b1, RTCV_OFS_TIME_MINUTES_SECONDS, 32'hFFFFFFFF);
		apb(1'b0, RTCV_OFS_TIME_MINUTES_SECONDS, 32'h0);
		chk(q, 32'h00007F7F);
		for (i = 0; i < 8; i++) begin
			v = pack(rn(6), rn(10), rn(6), rn(10));
			apb(1'b1, RTCV_OFS_TIME_MINUTES_SECONDS, {16'hA5A5, v | 16'h8080});
			apb(1'b0, RTCV_OFS_TIME_MINUTES_SECONDS, 32'h0);
			chk(q, {16'h0, v});
			w = pack(rn(6), rn(10), rn(6), rn(10));
			hw_time_minutes_seconds <= w | 16'h8080;
			hw_update <= 1'b1;
			@(posedge pclk);
			hw_update <= 1'b0;
			@(posedge pclk);
			chk({16'h0, tms}, {16'h0, w});
		end
		// Disabled writes must leave the alarm value at reset
		apb(1'b1, RTCV_OFS_CTRL, 32'h0);
		apb(1'b1, RTCV_OFS_ALMD, 32'h1F3F);
		apb(1'b0, RTCV_OFS_ALMD, 32'h0);
		chk(q, 32'h0);
		apb(1'b1, RTCV_OFS_CTRL, 32'h91);
		for (i = 0; i < 6; i++) begin
			v = pack(rn(2), rn(10), rn(4), rn(10));
			w = pack(0, rn(7), rn(3), rn(10));
			apb(1'b1, RTCV_OFS_ALMD, {16'hFFFF, v | 16'hE0C0});
			apb(1'b1, RTCV_OFS_ALWH, {16'hFFFF, w | 16'hF8C0});
			apb(1'b0, RTCV_OFS_ALMD, 32'h0);
			chk(q, {16'h0, v});
			apb(1'b0, RTCV_OFS_ALWH, 32'h0);
			chk(q, {16'h0, w});
		end
		apb(1'b1, RTCV_OFS_CTRL, 32'h90);
		apb(1'b1, RTCV_OFS_ALWH, 32'h0);
		apb(1'b0, RTCV_OFS_ALWH, 32'h0);
		chk(q, {16'h0, w});
		// Year mask: all compared digits equal, then one hour digit off
		apb(1'b1, RTCV_OFS_TIME_MINUTES_SECONDS, 32'h0);
		clk_month_day <= v;
		clk_weekday_digit_hour <= w;
		settle();
		chk({31'h0, alarm_match}, 32'h1);
		apb(1'b0, RTCV_OFS_STATUS, 32'h0);
		chk(q & 32'h1, 32'h1);
		clk_weekday_digit_hour <= w ^ 16'h0001;
		settle();
		chk({31'h0, alarm_match}, 32'h0);
		// Hour digit off: only masks that ignore hours still match
		for (i = 2; i < 11; i++) begin
			apb(1'b1, RTCV_OFS_CTRL, 32'(i << 4));
			settle();
			chk({31'h0, alarm_match}, {31'h0, i < 6});
		end
		apb(1'b1, RTCV_OFS_CTRL, 32'h00);
		settle();
		chk({31'h0, alarm_match}, 32'h1);
		apb(1'b0, 8'h1C, 32'h0);
		chk({31'h0, err}, 32'h1);
		stop_test();
	end
endmodule
`default_nettype wire
